// ==== rtl/ifcr_params.svh ====
// constants of the interrupt flag and control register bank
//------------------------------------------------------------------------
// Notes on behaviour
//------------------------------------------------------------------------
`ifndef IFCR_PARAMS_SVH
`define IFCR_PARAMS_SVH

//------------------------------------------------------------------------
// register word offsets
//------------------------------------------------------------------------
`define IFCR_OFS_CONTROL       4'h0
`define IFCR_OFS_FLAGS_ZERO    4'h1
`define IFCR_OFS_FLAGS_ONE     4'h2

//------------------------------------------------------------------------
// masks and reset values
//------------------------------------------------------------------------
`define IFCR_CTL_WR_MASK       16'h8007
`define IFCR_FLG0_MASK         16'h7FEF
`define IFCR_FLG1_MASK         16'hE87F
`define IFCR_RESET_VAL         16'h0000

//------------------------------------------------------------------------
// control field positions
//------------------------------------------------------------------------
`define IFCR_BIT_ALT_VECTOR    15
`define IFCR_BIT_DISABLE_ACT   14
`define IFCR_BIT_EXT2_POL      2
`define IFCR_BIT_EXT1_POL      1
`define IFCR_BIT_EXT0_POL      0

//------------------------------------------------------------------------
// flags zero positions
//------------------------------------------------------------------------
`define IFCR_BIT_TWOWIRE_MST   14
`define IFCR_BIT_TWOWIRE_SLV   13
`define IFCR_BIT_NONVOLATILE   12
`define IFCR_BIT_CONV_DONE     11
`define IFCR_BIT_SERIAL_TX     10
`define IFCR_BIT_SERIAL_RX     9
`define IFCR_BIT_SYNC_SERIAL   8
`define IFCR_BIT_TIMER_THREE   7
`define IFCR_BIT_TIMER_TWO     6
`define IFCR_BIT_COMPARE_TWO   5
`define IFCR_BIT_TIMER_ONE     3
`define IFCR_BIT_COMPARE_ONE   2
`define IFCR_BIT_CAPTURE_ONE   1
`define IFCR_BIT_EXT0_REQ      0

//------------------------------------------------------------------------
// flags one positions
//------------------------------------------------------------------------
`define IFCR_BIT_CMP_THREE     15
`define IFCR_BIT_CMP_TWO       14
`define IFCR_BIT_CMP_ONE       13
`define IFCR_BIT_CHANGE_NOTE   11
`define IFCR_BIT_PGEN_FOUR     6
`define IFCR_BIT_PGEN_THREE    5
`define IFCR_BIT_PGEN_TWO      4
`define IFCR_BIT_PGEN_ONE      3
`define IFCR_BIT_SPECIAL_EVT   2
`define IFCR_BIT_EXT2_REQ      1
`define IFCR_BIT_EXT1_REQ      0

`endif

// ==== rtl/ifcr_pkg.sv ====
// types shared by the interrupt flag and control register bank
package ifcr_pkg;
	typedef logic [15:0] ifcr_word_t;
	typedef logic [2:0]  ifcr_prio_t;
	typedef logic [4:0]  ifcr_index_t;
endpackage : ifcr_pkg

// ==== rtl/ifcr_regs.sv ====
// interrupt request flag and control register bank
`timescale 1ns/1ps
`include "ifcr_params.svh"

module ifcr_regs
	import ifcr_pkg::*;
#(
	parameter int ADDR_W = 4,
	parameter int PRIO_W = 3
) (
	input  wire logic                i_clk_sys,
	input  wire logic                i_rst_n,
	// register port
	input  wire logic [ADDR_W-1:0]   i_addr,
	input  wire logic [15:0]         i_wdata,
	input  wire logic                i_wr,
	input  wire logic                i_rd,
	output logic      [15:0]         o_rdata,
	// core status and timing
	input  wire logic                i_irq_disable_active,
	input  wire logic                i_insn_cycle_start,
	input  wire logic [PRIO_W-1:0]   i_cpu_priority_level,
	// enable registers and per-flag priorities held elsewhere
	input  wire logic [15:0]         i_irq_enable_regs0,
	input  wire logic [15:0]         i_irq_enable_regs1,
	input  wire logic [16*PRIO_W-1:0] i_prio_flags0,
	input  wire logic [16*PRIO_W-1:0] i_prio_flags1,
	// peripheral request pulses
	input  wire logic                i_twowire_master_evt,
	input  wire logic                i_twowire_slave_evt,
	input  wire logic                i_nonvolatile_evt,
	input  wire logic                i_conversion_done_evt,
	input  wire logic                i_serial_tx_evt,
	input  wire logic                i_serial_rx_evt,
	input  wire logic                i_sync_serial_evt,
	input  wire logic                i_timer_three_evt,
	input  wire logic                i_timer_two_evt,
	input  wire logic                i_compare_two_evt,
	input  wire logic                i_timer_one_evt,
	input  wire logic                i_compare_one_evt,
	input  wire logic                i_capture_one_evt,
	input  wire logic                i_comparator_three_evt,
	input  wire logic                i_comparator_two_evt,
	input  wire logic                i_comparator_one_evt,
	input  wire logic                i_change_notice_evt,
	input  wire logic                i_pulse_gen_four_evt,
	input  wire logic                i_pulse_gen_three_evt,
	input  wire logic                i_pulse_gen_two_evt,
	input  wire logic                i_pulse_gen_one_evt,
	input  wire logic                i_special_event_evt,
	// external request pins
	input  wire logic                i_ext0_pin,
	input  wire logic                i_ext1_pin,
	input  wire logic                i_ext2_pin,
	// outputs to the core
	output logic                     o_alt_vector_select,
	output logic      [15:0]         o_irq_flags_zero,
	output logic      [15:0]         o_irq_flags_one,
	output logic                     o_irq_request,
	output logic      [4:0]          o_irq_index,
	output logic      [PRIO_W-1:0]   o_irq_priority
);

	//--------------------------------------------------------------------
	// functions
	//--------------------------------------------------------------------

	// small helpers shared by the decode, the detectors and the arbiter,
	// so that every use of them reads the same way

	// edge detector: falling when polarity set, rising when clear
	// prev_v is the pin one cycle ago, cur_v the pin now
	function automatic logic f_edge(input logic prev_v,
		input logic cur_v, input logic pol);
		f_edge = pol ? (prev_v & ~cur_v) : (~prev_v & cur_v);
	endfunction : f_edge

	// register select from address
	// a wider address must be zero above the offset to match
	function automatic logic f_hit(input logic [ADDR_W-1:0] addr,
		input logic [3:0] ofs);
		f_hit = (addr == ADDR_W'(ofs));
	endfunction : f_hit

	// one flag's claim on the request: pending, enabled, above the cpu
	// level and strictly above the best claim so far, so that a tie
	// keeps the lower index
	function automatic logic f_beats(input logic flag_v,
		input logic en_v,
		input logic [PRIO_W-1:0] prio_v,
		input logic [PRIO_W-1:0] level_v,
		input logic any_v,
		input logic [PRIO_W-1:0] best_v);
		f_beats = flag_v & en_v & (prio_v > level_v) &
			(~any_v | (prio_v > best_v));
	endfunction : f_beats

	//--------------------------------------------------------------------
	// state
	//--------------------------------------------------------------------
	// the control word has only four bits of storage; the disable status
	// is never stored, it is read straight from the core each time
	logic                alt_vector_select_q;
	logic [2:0]          ext_polarity_q;
	ifcr_word_t          flags0_q;
	ifcr_word_t          flags0_d;
	ifcr_word_t          flags1_q;
	ifcr_word_t          flags1_d;
	ifcr_word_t          capt0_q;
	ifcr_word_t          capt1_q;
	ifcr_word_t          evt0;
	ifcr_word_t          evt1;
	ifcr_word_t          set0;
	ifcr_word_t          set1;
	logic [2:0]          pin_prev_q;
	logic                pin_valid_q;
	logic [2:0]          pin_cur;
	logic [2:0]          ext_edge;
	logic [15:0]         rdata_q;
	logic [15:0]         rdata_d;
	logic                irq_req_q;
	ifcr_index_t         irq_idx_q;
	logic [PRIO_W-1:0]   irq_prio_q;
	logic                win_any;
	ifcr_index_t         win_idx;
	logic [PRIO_W-1:0]   win_prio;
	logic                wr_ctl;
	logic                wr_flg0;
	logic                wr_flg1;

	//--------------------------------------------------------------------
	// address decode
	//--------------------------------------------------------------------
	// write selects; an unmapped address matches none of them, so a
	// stray write is simply dropped
	assign wr_ctl  = i_wr & f_hit(i_addr, `IFCR_OFS_CONTROL);
	assign wr_flg0 = i_wr & f_hit(i_addr, `IFCR_OFS_FLAGS_ZERO);
	assign wr_flg1 = i_wr & f_hit(i_addr, `IFCR_OFS_FLAGS_ONE);

	//--------------------------------------------------------------------
	// control register
	//--------------------------------------------------------------------

	// the disable status at bit 14 has no flop here: a write cannot
	// reach it, and a read always shows the core's present state
	// polarity bit i belongs to external pin i
	// only bits 15 and 2..0 are storage; the rest never see a write
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			alt_vector_select_q <= 1'b0;
			ext_polarity_q      <= 3'h0;
		end else if (wr_ctl) begin
			alt_vector_select_q <= i_wdata[`IFCR_BIT_ALT_VECTOR];
			ext_polarity_q      <= i_wdata[2:0];
		end
	end

	// a new table choice applies from the next vector fetch on
	// vector fetch logic in the core takes this for traps as well
	assign o_alt_vector_select = alt_vector_select_q;

	//--------------------------------------------------------------------
	// external pin edge detection
	//--------------------------------------------------------------------
	// pins are taken as already synchronous to the system clock; a pin
	// from another domain needs a synchroniser in front of this block
	assign pin_cur = {i_ext2_pin, i_ext1_pin, i_ext0_pin};

	// the valid bit keeps a pin already high at reset release from
	// looking like a rising edge
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pin_prev_q  <= 3'h0;
			pin_valid_q <= 1'b0;
		end else begin
			pin_prev_q  <= pin_cur;
			pin_valid_q <= 1'b1;
		end
	end

	// a polarity write while a pin sits still makes no edge, since only
	// the pin itself is compared with its previous value
	// one detector per pin; a steady level never fires
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			ext_edge[i] = pin_valid_q &
				f_edge(pin_prev_q[i], pin_cur[i], ext_polarity_q[i]);
		end
	end

	//--------------------------------------------------------------------
	// event vectors in register layout
	//--------------------------------------------------------------------
	// peripheral pulses placed at their flag positions; holes stay zero
	// so the masks below never see a stray bit
	always_comb begin
		evt0 = 16'h0000;
		evt0[`IFCR_BIT_TWOWIRE_MST] = i_twowire_master_evt;
		evt0[`IFCR_BIT_TWOWIRE_SLV] = i_twowire_slave_evt;
		evt0[`IFCR_BIT_NONVOLATILE] = i_nonvolatile_evt;
		evt0[`IFCR_BIT_CONV_DONE]   = i_conversion_done_evt;
		evt0[`IFCR_BIT_SERIAL_TX]   = i_serial_tx_evt;
		evt0[`IFCR_BIT_SERIAL_RX]   = i_serial_rx_evt;
		evt0[`IFCR_BIT_SYNC_SERIAL] = i_sync_serial_evt;
		evt0[`IFCR_BIT_TIMER_THREE] = i_timer_three_evt;
		evt0[`IFCR_BIT_TIMER_TWO]   = i_timer_two_evt;
		evt0[`IFCR_BIT_COMPARE_TWO] = i_compare_two_evt;
		evt0[`IFCR_BIT_TIMER_ONE]   = i_timer_one_evt;
		evt0[`IFCR_BIT_COMPARE_ONE] = i_compare_one_evt;
		evt0[`IFCR_BIT_CAPTURE_ONE] = i_capture_one_evt;
		evt0[`IFCR_BIT_EXT0_REQ]    = ext_edge[0];
	end

	// second flag word: comparators, change notice, pulse generators and
	// the two remaining external pins
	always_comb begin
		evt1 = 16'h0000;
		evt1[`IFCR_BIT_CMP_THREE]   = i_comparator_three_evt;
		evt1[`IFCR_BIT_CMP_TWO]     = i_comparator_two_evt;
		evt1[`IFCR_BIT_CMP_ONE]     = i_comparator_one_evt;
		evt1[`IFCR_BIT_CHANGE_NOTE] = i_change_notice_evt;
		evt1[`IFCR_BIT_PGEN_FOUR]   = i_pulse_gen_four_evt;
		evt1[`IFCR_BIT_PGEN_THREE]  = i_pulse_gen_three_evt;
		evt1[`IFCR_BIT_PGEN_TWO]    = i_pulse_gen_two_evt;
		evt1[`IFCR_BIT_PGEN_ONE]    = i_pulse_gen_one_evt;
		evt1[`IFCR_BIT_SPECIAL_EVT] = i_special_event_evt;
		evt1[`IFCR_BIT_EXT2_REQ]    = ext_edge[2];
		evt1[`IFCR_BIT_EXT1_REQ]    = ext_edge[1];
	end

	//--------------------------------------------------------------------
	// capture between instruction cycle starts
	//--------------------------------------------------------------------

	// pulses between cycle starts are held here so none is missed;
	// costs one capture bit per source; a pulse in a cycle-start cycle
	// goes straight through the set path and is not held again
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			capt0_q <= `IFCR_RESET_VAL;
			capt1_q <= `IFCR_RESET_VAL;
		end else if (i_insn_cycle_start) begin
			capt0_q <= 16'h0000;
			capt1_q <= 16'h0000;
		end else begin
			capt0_q <= capt0_q | (evt0 & `IFCR_FLG0_MASK);
			capt1_q <= capt1_q | (evt1 & `IFCR_FLG1_MASK);
		end
	end

	// events enter the flags only at an instruction cycle start
	// outside a cycle start nothing is set, whatever the sources do
	assign set0 = i_insn_cycle_start ?
		((capt0_q | evt0) & `IFCR_FLG0_MASK) : 16'h0000;
	assign set1 = i_insn_cycle_start ?
		((capt1_q | evt1) & `IFCR_FLG1_MASK) : 16'h0000;

	//--------------------------------------------------------------------
	// flag registers
	//--------------------------------------------------------------------

	// a write replaces implemented bits; a coincident set still wins
	// a software clear never discards held events: the capture bits are
	// separate, so an event after the clear shows at the next start;
	// the set path is or-ed in last, which is what makes the set win
	always_comb begin
		flags0_d = flags0_q;
		flags1_d = flags1_q;
		if (wr_flg0) begin
			flags0_d = i_wdata & `IFCR_FLG0_MASK;
		end
		if (wr_flg1) begin
			flags1_d = i_wdata & `IFCR_FLG1_MASK;
		end
		flags0_d = flags0_d | set0;
		flags1_d = flags1_d | set1;
	end

	// flag storage; only reset and the next-value logic above touch it
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			flags0_q <= `IFCR_RESET_VAL;
			flags1_q <= `IFCR_RESET_VAL;
		end else begin
			flags0_q <= flags0_d;
			flags1_q <= flags1_d;
		end
	end

	// flags go to the core unmasked by enable; the arbiter does that
	assign o_irq_flags_zero = flags0_q;
	assign o_irq_flags_one  = flags1_q;

	//--------------------------------------------------------------------
	// read path
	//--------------------------------------------------------------------

	// the read is decoded in the strobe cycle and registered, so the
	// data stand in the next cycle only; an idle bus reads as zero
	// unmapped addresses and unimplemented bits read as zero
	// control bits 13..3 keep the zero default
	always_comb begin
		rdata_d = 16'h0000;
		if (!i_rd) begin
			rdata_d = 16'h0000;
		end else if (f_hit(i_addr, `IFCR_OFS_CONTROL)) begin
			rdata_d[`IFCR_BIT_ALT_VECTOR]  = alt_vector_select_q;
			rdata_d[`IFCR_BIT_DISABLE_ACT] = i_irq_disable_active;
			rdata_d[2:0] = ext_polarity_q;
		end else if (f_hit(i_addr, `IFCR_OFS_FLAGS_ZERO)) begin
			rdata_d = flags0_q & `IFCR_FLG0_MASK;
		end else if (f_hit(i_addr, `IFCR_OFS_FLAGS_ONE)) begin
			rdata_d = flags1_q & `IFCR_FLG1_MASK;
		end
	end

	// data stand only in the cycle after the read strobe
	// one flop on the read data keeps the bus timing simple
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rdata_q <= 16'h0000;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign o_rdata = rdata_q;

	//--------------------------------------------------------------------
	// request arbitration
	//--------------------------------------------------------------------

	// highest priority above the cpu level wins; lower index on a tie
	// one combinational pass over all 32 flags, the longest path in the
	// block; flags zero go first, so they win a tie
	always_comb begin
		win_any  = 1'b0;
		win_idx  = 5'h00;
		win_prio = '0;
		for (int i = 0; i < 16; i++) begin
			if (f_beats(flags0_q[i], i_irq_enable_regs0[i],
				i_prio_flags0[i*PRIO_W +: PRIO_W], i_cpu_priority_level,
				win_any, win_prio)) begin
				win_any  = 1'b1;
				win_idx  = 5'(i);
				win_prio = i_prio_flags0[i*PRIO_W +: PRIO_W];
			end
		end
		for (int i = 0; i < 16; i++) begin
			if (f_beats(flags1_q[i], i_irq_enable_regs1[i],
				i_prio_flags1[i*PRIO_W +: PRIO_W], i_cpu_priority_level,
				win_any, win_prio)) begin
				win_any  = 1'b1;
				win_idx  = 5'(i + 16);
				win_prio = i_prio_flags1[i*PRIO_W +: PRIO_W];
			end
		end
	end

	// registered request; one cycle behind the flags
	// registered so that the core never sees a glitch on the request
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			irq_req_q  <= 1'b0;
			irq_idx_q  <= 5'h00;
			irq_prio_q <= '0;
		end else begin
			irq_req_q  <= win_any;
			irq_idx_q  <= win_idx;
			irq_prio_q <= win_prio;
		end
	end

	// request, index and priority always change together
	assign o_irq_request  = irq_req_q;
	assign o_irq_index    = irq_idx_q;
	assign o_irq_priority = irq_prio_q;

endmodule : ifcr_regs

// ==== dv/ifcr_regs_props.sv ====
// port checker for the interrupt flag and control bank
`timescale 1ns/1ps
module ifcr_regs_props #(
	parameter int ADDR_W = 4
) (
	input wire logic              i_clk_sys,
	input wire logic              i_rst_n,
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [15:0]       i_wdata,
	input wire logic              i_wr,
	input wire logic              i_rd,
	input wire logic [15:0]       o_rdata,
	input wire logic              i_irq_disable_active,
	input wire logic              i_insn_cycle_start,
	input wire logic              i_timer_one_evt,
	input wire logic              i_pulse_gen_one_evt,
	input wire logic              o_alt_vector_select,
	input wire logic [15:0]       o_irq_flags_zero,
	input wire logic [15:0]       o_irq_flags_one
);
	// ----
	// port relations
	// ----
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_rst_n);
	// status bit is the live core level, not a stored copy
	a_ctl_read: assert property (
		$past(i_rd) && $past(i_addr) == '0 |-> o_rdata[15:3] ==
		{$past(o_alt_vector_select), $past(i_irq_disable_active), 11'h000})
		else $error("control read wrong");
	a_flags_read: assert property (
		$past(i_rd) && $past(i_addr) == ADDR_W'(1) |->
		o_rdata == $past(o_irq_flags_zero))
		else $error("flags read wrong");
	a_alt_write: assert property (
		i_wr && i_addr == '0 |=> o_alt_vector_select == $past(i_wdata[15]))
		else $error("table select not written");
	a_flag0_holes: assert property (
		(o_irq_flags_zero & 16'h8010) == 16'h0000)
		else $error("unused flag zero bit set");
	a_flag1_holes: assert property (
		(o_irq_flags_one & 16'h1780) == 16'h0000)
		else $error("unused flag one bit set");
	// only a software write to the register may drop a flag
	a_flag_sticky: assert property (
		!(i_wr && i_addr == ADDR_W'(1)) |=>
		(o_irq_flags_zero & $past(o_irq_flags_zero)) == $past(o_irq_flags_zero))
		else $error("flag dropped without write");
	a_set_cause: assert property (
		(o_irq_flags_zero & ~$past(o_irq_flags_zero)) != 16'h0000 |->
		$past(i_insn_cycle_start) || ($past(i_wr) && $past(i_addr) == 1))
		else $error("flag rose off cycle start");
	a_timer_set: assert property (
		i_insn_cycle_start && i_timer_one_evt |=> o_irq_flags_zero[3])
		else $error("timer flag missed");
	a_pgen_set: assert property (
		i_insn_cycle_start && i_pulse_gen_one_evt |=> o_irq_flags_one[3])
		else $error("pulse flag missed");
	c_clash: cover property (i_insn_cycle_start && i_timer_one_evt && i_wr);
	c_status: cover property ($past(i_rd) && o_rdata[14]);
	c_alt: cover property (o_alt_vector_select);
endmodule : ifcr_regs_props

bind ifcr_regs ifcr_regs_props #(.ADDR_W(ADDR_W)) u_props (
	.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_addr(i_addr),
	.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
	.i_irq_disable_active(i_irq_disable_active),
	.i_insn_cycle_start(i_insn_cycle_start),
	.i_timer_one_evt(i_timer_one_evt),
	.i_pulse_gen_one_evt(i_pulse_gen_one_evt),
	.o_alt_vector_select(o_alt_vector_select),
	.o_irq_flags_zero(o_irq_flags_zero), .o_irq_flags_one(o_irq_flags_one));

// ==== dv/ifcr_core_model.sv ====
// core-side model that paces instruction cycles
`timescale 1ns/1ps
module ifcr_core_model #(
	parameter int PERIOD = 4
) (
	input  wire logic i_clk_sys,
	input  wire logic i_rst_n,
	output logic      o_insn_cycle_start
);
	// ----
	// instruction cycle pacing
	// ----
	logic [3:0] cnt_q;
	// free-running: the bank must catch events between pulses itself
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt_q <= 4'h0;
			o_insn_cycle_start <= 1'b0;
		end else begin
			cnt_q <= (cnt_q == 4'(PERIOD - 1)) ? 4'h0 : cnt_q + 4'h1;
			o_insn_cycle_start <= (cnt_q == 4'(PERIOD - 1));
		end
	end
endmodule : ifcr_core_model

// ==== dv/test_interrupt_flag_and_control_regs.sv ====
// self-checking bench for the interrupt flag and control bank
`timescale 1ns/1ps
module test_interrupt_flag_and_control_regs
	import ifcr_pkg::*;
;
	// ----
	// signals
	// ----
	logic       clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
	logic       dis = 1'b0, cs, alt, req;
	logic [3:0] addr = 4'h0;
	logic [2:0] pin = 3'h0, lvl = 3'h0, ipr;
	logic [4:0] idx;
	logic [47:0] pr0 = 48'h0, pr1 = 48'h0;
	ifcr_word_t wdata = 16'h0000, ev0 = 16'h0000, ev1 = 16'h0000;
	ifcr_word_t en0 = 16'h0000, en1 = 16'h0000, rdata, f0, f1;
	ifcr_word_t src [2] = '{16'h7FEE, 16'hE87C};
	int         err_count = 0, n_compared = 0;

	always #2.5 clk = ~clk;

	ifcr_core_model u_core (.i_clk_sys(clk), .i_rst_n(rst_n),
		.o_insn_cycle_start(cs));

	ifcr_regs dut (
		.i_clk_sys(clk), .i_rst_n(rst_n), .i_addr(addr),
		.i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
		.i_irq_disable_active(dis), .i_insn_cycle_start(cs),
		.i_cpu_priority_level(lvl), .i_irq_enable_regs0(en0),
		.i_irq_enable_regs1(en1), .i_prio_flags0(pr0),
		.i_prio_flags1(pr1),
		.i_twowire_master_evt(ev0[14]), .i_twowire_slave_evt(ev0[13]),
		.i_nonvolatile_evt(ev0[12]), .i_conversion_done_evt(ev0[11]),
		.i_serial_tx_evt(ev0[10]), .i_serial_rx_evt(ev0[9]),
		.i_sync_serial_evt(ev0[8]), .i_timer_three_evt(ev0[7]),
		.i_timer_two_evt(ev0[6]), .i_compare_two_evt(ev0[5]),
		.i_timer_one_evt(ev0[3]), .i_compare_one_evt(ev0[2]),
		.i_capture_one_evt(ev0[1]), .i_comparator_three_evt(ev1[15]),
		.i_comparator_two_evt(ev1[14]), .i_comparator_one_evt(ev1[13]),
		.i_change_notice_evt(ev1[11]), .i_pulse_gen_four_evt(ev1[6]),
		.i_pulse_gen_three_evt(ev1[5]), .i_pulse_gen_two_evt(ev1[4]),
		.i_pulse_gen_one_evt(ev1[3]), .i_special_event_evt(ev1[2]),
		.i_ext0_pin(pin[0]), .i_ext1_pin(pin[1]), .i_ext2_pin(pin[2]),
		.o_alt_vector_select(alt), .o_irq_flags_zero(f0),
		.o_irq_flags_one(f1), .o_irq_request(req), .o_irq_index(idx),
		.o_irq_priority(ipr));

	// ----
	// bus and check tasks
	// ----
	task automatic chk(input ifcr_word_t got, input ifcr_word_t exp);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic wr_reg(input logic [3:0] a, input ifcr_word_t d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg

	// read data live one cycle only, so look just after that edge
	task automatic rd_reg(input logic [3:0] a, input ifcr_word_t e);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk(rdata, e);
	endtask : rd_reg

	task automatic done(input string s);
		$display("test %s done", s);
	endtask : done

	task automatic end_sim;
		$display("compared %0d mismatched %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : end_sim

	// hang guard, far beyond the several hundred cycles the tests need
	initial begin
		#50000;
		err_count++;
		end_sim;
	end

	// ----
	// test sequence
	// ----
	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		for (int a = 0; a < 3; a++)
			rd_reg(4'(a), 16'h0000);
		wr_reg(4'hF, 16'hFFFF);
		rd_reg(4'hF, 16'h0000);
		done("reset");
		@(posedge clk);
		dis <= 1'b1;
		wr_reg(4'h0, 16'hFFFF);
		rd_reg(4'h0, 16'hC007);
		chk({15'h0000, alt}, 16'h0001);
		wr_reg(4'h0, 16'h0000);
		rd_reg(4'h0, 16'h4000);
		chk({15'h0000, alt}, 16'h0000);
		@(posedge clk);
		dis <= 1'b0;
		wr_reg(4'h1, 16'hFFFF);
		rd_reg(4'h1, 16'h7FEF);
		wr_reg(4'h2, 16'hFFFF);
		rd_reg(4'h2, 16'hE87F);
		wr_reg(4'h1, 16'h0000);
		wr_reg(4'h2, 16'h0000);
		rd_reg(4'h1, 16'h0000);
		rd_reg(4'h2, 16'h0000);
		done("registers");
		// every peripheral source, one at a time
		for (int i = 0; i < 32; i++) begin
			if (src[i / 16][i % 16]) begin
				@(posedge clk);
				if (i < 16)
					ev0[i % 16] <= 1'b1;
				else
					ev1[i % 16] <= 1'b1;
				@(posedge clk);
				ev0 <= 16'h0000;
				ev1 <= 16'h0000;
				repeat (6) @(posedge clk);
				rd_reg(4'(i / 16 + 1), 16'h0001 << (i % 16));
				repeat (8) @(posedge clk);
				rd_reg(4'(i / 16 + 1), 16'h0001 << (i % 16));
				wr_reg(4'(i / 16 + 1), 16'h0000);
			end
		end
		done("sources");
		// external pins: rising, held level, then falling
		for (int k = 0; k < 3; k++) begin
			logic [3:0] a;
			ifcr_word_t e;
			a = (k == 0) ? 4'h1 : 4'h2;
			e = (k == 2) ? 16'h0002 : 16'h0001;
			@(posedge clk);
			pin[k] <= 1'b1;
			repeat (8) @(posedge clk);
			rd_reg(a, e);
			wr_reg(a, 16'h0000);
			repeat (8) @(posedge clk);
			rd_reg(a, 16'h0000);
			wr_reg(4'h0, 16'h0001 << k);
			rd_reg(4'h0, 16'h0001 << k);
			@(posedge clk);
			pin[k] <= 1'b0;
			repeat (8) @(posedge clk);
			rd_reg(a, e);
			wr_reg(a, 16'h0000);
			wr_reg(4'h0, 16'h0000);
		end
		done("pins");
		// clear write lands on a cycle-start edge together with an event pulse
		@(posedge clk iff cs);
		repeat (3) @(posedge clk);
		wr <= 1'b1;
		addr <= 4'h1;
		wdata <= 16'h0000;
		ev0[3] <= 1'b1;
		ev1[3] <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		ev0[3] <= 1'b0;
		ev1[3] <= 1'b0;
		rd_reg(4'h1, 16'h0008);
		rd_reg(4'h2, 16'h0008);
		done("clash");
		wr_reg(4'h1, 16'h0008);
		en0 <= 16'h0008;
		pr0[11:9] <= 3'h5;
		lvl <= 3'h4;
		repeat (3) @(posedge clk);
		#1 chk({7'h00, req, ipr, idx}, 16'h01A3);
		@(posedge clk);
		lvl <= 3'h5;
		repeat (3) @(posedge clk);
		#1 chk({15'h0000, req}, 16'h0000);
		@(posedge clk);
		lvl <= 3'h4;
		en0 <= 16'h0000;
		repeat (3) @(posedge clk);
		#1 chk({15'h0000, req}, 16'h0000);
		// a flags one source above the flags zero claim takes over
		@(posedge clk);
		en0 <= 16'h0008;
		en1 <= 16'h0008;
		pr1[11:9] <= 3'h6;
		repeat (3) @(posedge clk);
		#1 chk({7'h00, req, ipr, idx}, 16'h01D3);
		chk(f0, 16'h0008);
		chk(f1, 16'h0008);
		done("request");
		// reset in mid-run clears every flag and drops the request
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		#1 chk({15'h0000, req}, 16'h0000);
		chk(f0 | f1, 16'h0000);
		rd_reg(4'h0, 16'h0000);
		done("reset again");
		end_sim;
	end
endmodule : test_interrupt_flag_and_control_regs
